// ==== core/sspp_pkg.sv ====
// Package: shared constants and carriers for the serial slave port
package sspp_pkg;
  localparam int unsigned SSPP_BYTE_W     = 8;
  localparam int unsigned SSPP_SYNC_STAGE = 2;
  localparam int unsigned SSPP_CNT_W      = 3;
  localparam logic [2:0]  SSPP_CNT_LAST   = 3'h7;
  localparam logic [2:0]  SSPP_CNT_ZERO   = 3'h0;
  localparam logic [7:0]  SSPP_BYTE_ZERO  = 8'h00;
  localparam logic [1:0]  SSPP_SYNC_IDLE  = 2'h3;
  localparam logic [1:0]  SSPP_SYNC_LOW   = 2'h0;
  // Synchronised pin levels
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic mosi;
  } sspp_pins_t;
  // Transfer state
  typedef enum logic [2:0] {
    SSPP_IDLE  = 3'b001,
    SSPP_SHIFT = 3'b010,
    SSPP_END   = 3'b100
  } sspp_state_t;
endpackage : sspp_pkg

// ==== core/sspp_sync.sv ====
// Two-flop synchroniser for one pin
`timescale 1ns/1ps
module sspp_sync
  import sspp_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta;
  // Stage one is read only by stage two
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      meta   <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : sspp_sync

// ==== core/sspp_core.sv ====
// Serial slave port: mode 0 SPI slave, bytes in and out
//
// Function
// - Master-out is always an input, sampled most significant bit first.
// - Slave-out returns data most significant bit first, output only.
// - Slave-out floats whenever select is high.
// - Clock edges are ignored while select is high.
// - Select falling starts a transfer, rising ends it.
// - Synchronous write-only rate up to one quarter of system clock.
// - Bits shift only on master clock edges.
`timescale 1ns/1ps
module sspp_core
  import sspp_pkg::*;
#(
  parameter int unsigned BYTE_W = SSPP_BYTE_W
) (
  input  wire logic              mclk_i,
  input  wire logic              srst_i,
  input  wire logic              sel_n_i,
  input  wire logic              sck_i,
  input  wire logic              mosi_i,
  output logic                   miso_o,
  output logic                   miso_oe_o,
  output logic [BYTE_W-1:0]      rx_data_o,
  output logic                   rx_valid_o,
  input  wire logic [BYTE_W-1:0] tx_data_i,
  output logic                   tx_load_o,
  output logic                   frame_start_o,
  output logic                   frame_end_o,
  output logic                   busy_o
);
  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  sspp_pins_t pins;
  logic       sel_sync;
  logic       sck_sync;
  logic       mosi_sync;
  sspp_sync #(.RESET_VAL(1'b1)) u_sel (
    .mclk_i (mclk_i), .srst_i (srst_i), .async_i (sel_n_i), .sync_o (sel_sync));
  sspp_sync #(.RESET_VAL(1'b0)) u_sck (
    .mclk_i (mclk_i), .srst_i (srst_i), .async_i (sck_i), .sync_o (sck_sync));
  sspp_sync #(.RESET_VAL(1'b0)) u_mosi (
    .mclk_i (mclk_i), .srst_i (srst_i), .async_i (mosi_i), .sync_o (mosi_sync));
  // One driver for the whole carrier, not one per field
  assign pins = '{sel_n: sel_sync, sck: sck_sync, mosi: mosi_sync};

  // ---------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------
  logic sel_d;
  logic sck_d;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sel_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      sel_d <= pins.sel_n;
      sck_d <= pins.sck;
    end
  end
  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  assign sel_fall = sel_d & ~pins.sel_n;
  assign sel_rise = ~sel_d & pins.sel_n;
  // Edges only count inside a frame
  // Two synchronised cycles per phase suffice, so quarter rate is met
  assign sck_rise = ~pins.sel_n & ~sck_d & pins.sck;
  assign sck_fall = ~pins.sel_n & sck_d & ~pins.sck;

  // ---------------------------------------------------------------
  // Frame state
  // ---------------------------------------------------------------
  // A select pulse shorter than the synchroniser, once sampled, is still seen as a frame
  sspp_state_t state;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= SSPP_IDLE;
    end else begin
      case (state)
        SSPP_IDLE: begin
          if (sel_fall) begin
            state <= SSPP_SHIFT;
          end
        end
        SSPP_SHIFT: begin
          if (sel_rise) begin
            state <= SSPP_END;
          end
        end
        SSPP_END: begin
          state <= SSPP_IDLE;
        end
        default: begin
          state <= SSPP_IDLE;
        end
      endcase
    end
  end
  logic in_frame;
  assign in_frame = (state == SSPP_SHIFT) & ~pins.sel_n;

  // ---------------------------------------------------------------
  // Receive shifter
  // ---------------------------------------------------------------
  logic [BYTE_W-1:0]     rx_shift;
  logic [SSPP_CNT_W-1:0] bit_cnt;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rx_shift   <= SSPP_BYTE_ZERO;
      bit_cnt    <= SSPP_CNT_ZERO;
      rx_data_o  <= SSPP_BYTE_ZERO;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      // Partial byte at frame end is dropped: count clears outside a frame
      if (state != SSPP_SHIFT) begin
        bit_cnt <= SSPP_CNT_ZERO;
      end else if (in_frame && sck_rise) begin
        // Sample on rising edge, first bit is the msb
        rx_shift <= {rx_shift[BYTE_W-2:0], pins.mosi};
        bit_cnt  <= bit_cnt + 3'h1;
        if (bit_cnt == SSPP_CNT_LAST) begin
          rx_data_o  <= {rx_shift[BYTE_W-2:0], pins.mosi};
          rx_valid_o <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmit shifter
  // ---------------------------------------------------------------
  // Mode 0 needs the msb out before the first rising edge, so a byte
  // loads at frame start and after each eighth rising edge.
  logic [BYTE_W-1:0] tx_shift;
  logic              reload;
  assign reload = in_frame && sck_rise && (bit_cnt == SSPP_CNT_LAST);
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_shift  <= SSPP_BYTE_ZERO;
      tx_load_o <= 1'b0;
    end else begin
      tx_load_o <= sel_fall | reload;
      // Loaded twice per start so a late tx_data_i still lands
      if (sel_fall || tx_load_o) begin
        tx_shift <= tx_data_i;
      end else if (in_frame && sck_fall && bit_cnt != SSPP_CNT_ZERO) begin
        tx_shift <= {tx_shift[BYTE_W-2:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers and status
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      miso_o        <= 1'b0;
      miso_oe_o     <= 1'b0;
      frame_start_o <= 1'b0;
      frame_end_o   <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      // Registered pin costs a cycle, still well inside one clock phase
      miso_o        <= tx_shift[BYTE_W-1];
      miso_oe_o     <= in_frame;
      frame_start_o <= sel_fall;
      frame_end_o   <= sel_rise & (state == SSPP_SHIFT);
      busy_o        <= (state == SSPP_SHIFT);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  AST_MISO_FLOAT: assert property (pins.sel_n |=> !miso_oe_o)
    else $error("slave-out driven while select high");
  AST_NO_SHIFT_IDLE: assert property (pins.sel_n |=> !rx_valid_o)
    else $error("byte completed while select high");
  AST_CNT_HOLD: assert property (pins.sel_n && state != SSPP_SHIFT |=> bit_cnt == SSPP_CNT_ZERO)
    else $error("bit count moved outside frame");
  AST_START: assert property (sel_fall && state == SSPP_IDLE |=> state == SSPP_SHIFT ##0 frame_start_o)
    else $error("frame start missed");
  AST_END: assert property (sel_rise && state == SSPP_SHIFT |=> state == SSPP_END ##1 state == SSPP_IDLE)
    else $error("frame end missed");
  AST_NO_EDGE_NO_BIT: assert property (!sck_rise |=> $stable(rx_shift))
    else $error("shift without clock edge");
  AST_MSB_FIRST: assert property (in_frame && sck_rise |=> rx_shift[0] == $past(pins.mosi))
    else $error("received bit misplaced");
  AST_BYTE_OUT: assert property (reload |=> rx_valid_o && rx_data_o[0] == $past(pins.mosi))
    else $error("byte not delivered");
  AST_MISO_MSB: assert property (1'b1 |=> miso_o == $past(tx_shift[BYTE_W-1]))
    else $error("slave-out not msb");
  AST_SYNC_LAT: assert property ($rose(pins.sel_n) |-> $past(sel_n_i, 2))
    else $error("select not synchronised");
  AST_LOAD_START: assert property (sel_fall |=> tx_load_o && frame_start_o)
    else $error("no load at frame start");
  AST_LOAD_RELOAD: assert property (reload |=> tx_load_o)
    else $error("no reload after eighth bit");
  AST_END_PULSE: assert property (sel_rise && state == SSPP_SHIFT |=> frame_end_o)
    else $error("frame end pulse missed");
  AST_NO_TX_IDLE: assert property (pins.sel_n && !tx_load_o |=> $stable(tx_shift))
    else $error("transmit shifter moved while select high");
  AST_CNT_WRAP: assert property (reload |=> bit_cnt == SSPP_CNT_ZERO)
    else $error("bit count did not wrap");

  // ---------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------
  COV_FRAME: cover property (sel_fall ##[1:200] sel_rise);
  COV_BYTE: cover property (rx_valid_o);
  COV_TWO_BYTES: cover property (rx_valid_o ##[1:400] rx_valid_o);
  // Clock activity while deselected must leave no trace
  COV_NOISE: cover property (pins.sel_n && sck_d && !pins.sck);
endmodule : sspp_core

// ==== tb/sspp_master_model.sv ====
// Behavioural mode 0 SPI master
`timescale 1ns/1ps
module sspp_master_model (
  input  wire logic mclk_i,
  output logic      sel_n_o,
  output logic      sck_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  logic       last_miso = 1'b0;
  logic [7:0] got       = 8'h00;
  logic       miso_w;
  // Released line shows inverse of last level, never a stale copy
  assign miso_w = miso_oe_i ? miso_i : ~last_miso;
  initial begin
    sel_n_o = 1'b1;
    sck_o   = 1'b0;
    mosi_o  = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : wait_n
  // Single select line: this device only
  task automatic sel(input logic lvl);
    wait_n(2);
    sel_n_o = lvl;
    wait_n(8);
  endtask : sel
  // Data set while clock low, sampled on rise; half sets the rate
  task automatic shift(input logic [7:0] d, input int nbits, input int half);
    for (int i = 7; i >= 8 - nbits; i--) begin
      mosi_o = d[i];
      wait_n(half);
      sck_o     = 1'b1;
      got       = {got[6:0], miso_w};
      last_miso = miso_w;
      wait_n(half);
      sck_o = 1'b0;
    end
  endtask : shift
endmodule : sspp_master_model

// ==== tb/sspp_core_tb_top.sv ====
// Self-checking bench for the serial slave port
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module sspp_core_tb_top;
  import sspp_pkg::*;
  logic       mclk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic [7:0] tx_data = 8'ha5;
  logic       sel_n, sck, mosi, miso, miso_oe, rx_valid, tx_load, f_start, f_end, busy;
  logic [7:0] rx_data;
  int         fail_count = 0;
  int         n_checks = 0;
  int         n_rx = 0;
  int         base;
  int         n_start = 0;
  int         n_end = 0;
  int         n_load = 0;
  int         b_start;
  int         b_end;
  int         b_load;
  always #50 mclk_i = ~mclk_i;
  // Pulses read mid-cycle, clear of the edge that launches them
  always @(negedge mclk_i) begin
    if (rx_valid === 1'b1) n_rx++;
    if (f_start === 1'b1) n_start++;
    if (f_end === 1'b1) n_end++;
    if (tx_load === 1'b1) n_load++;
  end
  sspp_master_model sspp_master_model_i (.mclk_i(mclk_i), .sel_n_o(sel_n), .sck_o(sck), .mosi_o(mosi),
    .miso_i(miso), .miso_oe_i(miso_oe));
  sspp_core sspp_core_i (.mclk_i(mclk_i), .srst_i(srst_i), .sel_n_i(sel_n), .sck_i(sck), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .tx_data_i(tx_data),
    .tx_load_o(tx_load), .frame_start_o(f_start), .frame_end_o(f_end), .busy_o(busy));
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic snap();
    base    = n_rx;
    b_start = n_start;
    b_end   = n_end;
    b_load  = n_load;
  endtask : snap
  // Two bytes back to back, one tenth rate
  task automatic t_duplex();
    snap();
    sspp_master_model_i.sel(1'b0);
    `CHK(miso_oe, 1'b1, "slave-out not driven")
    `CHK(busy, 1'b1, "no frame seen")
    `CHK(n_start - b_start, 1, "start pulse")
    sspp_master_model_i.shift(8'h3c, 8, 5);
    `CHK(rx_data, 8'h3c, "first byte")
    `CHK(sspp_master_model_i.got, 8'ha5, "first slave-out byte")
    sspp_master_model_i.shift(8'h81, 8, 5);
    `CHK(rx_data, 8'h81, "second byte")
    `CHK(sspp_master_model_i.got, 8'ha5, "slave-out byte")
    `CHK(n_rx - base, 2, "byte count")
    sspp_master_model_i.sel(1'b1);
    `CHK(miso_oe, 1'b0, "slave-out not released")
    `CHK(busy, 1'b0, "frame not closed")
    `CHK(n_end - b_end, 1, "end pulse")
    `CHK(n_load - b_load, 3, "load pulses")
    $display("test duplex done");
  endtask : t_duplex
  // Clock noise while deselected
  task automatic t_noise();
    snap();
    sspp_master_model_i.shift(8'hff, 8, 5);
    `CHK(n_rx - base, 0, "bits taken while deselected")
    `CHK(miso_oe, 1'b0, "driven while deselected")
    `CHK(n_start - b_start, 0, "start while deselected")
    `CHK(n_load - b_load, 0, "load while deselected")
    $display("test noise done");
  endtask : t_noise
  // Partial byte dropped, count restarts in next frame
  task automatic t_partial();
    snap();
    sspp_master_model_i.sel(1'b0);
    sspp_master_model_i.shift(8'hf0, 4, 5);
    sspp_master_model_i.sel(1'b1);
    sspp_master_model_i.sel(1'b0);
    sspp_master_model_i.shift(8'h5a, 8, 5);
    sspp_master_model_i.sel(1'b1);
    `CHK(rx_data, 8'h5a, "byte after partial")
    `CHK(n_rx - base, 1, "partial byte kept")
    `CHK(sspp_master_model_i.got, 8'h96, "slave-out after partial")
    `CHK(n_end - b_end, 2, "two frames closed")
    $display("test partial done");
  endtask : t_partial
  // Write-only at the 800 ns link clock
  task automatic t_write_only();
    snap();
    sspp_master_model_i.sel(1'b0);
    sspp_master_model_i.shift(8'hc3, 8, 4);
    sspp_master_model_i.shift(8'h18, 8, 4);
    sspp_master_model_i.sel(1'b1);
    `CHK(rx_data, 8'h18, "fast byte")
    `CHK(n_rx - base, 2, "fast byte count")
    `CHK(n_load - b_load, 3, "reloads at write rate")
    $display("test write_only done");
  endtask : t_write_only
  initial begin
    repeat (6) @(negedge mclk_i);
    srst_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    t_duplex();
    t_noise();
    tx_data = 8'h96;
    t_partial();
    t_write_only();
    close_out();
  end
  // Tests need about 580 cycles; allow over thirty times that
  initial begin
    #2000000;
    fail_count++;
    close_out();
  end
endmodule : sspp_core_tb_top
